// *** core/swt_timer.v ***
`include "swt_defs.vh"

module swt_timer #(
	parameter WIDTH = 8
) (
	input wire clk_i,
	input wire rst_n_i,
	input wire [7:0] sfr_addr_i,
	input wire sfr_wr_i,
	input wire [7:0] sfr_wdata_i,
	input wire cap_low_i,
	input wire cap_high_i,
	output reg [7:0] sfr_rdata_o,
	output reg irq_o
);

	// ----------------------------------------
	// control and reload storage
	// ----------------------------------------
	reg [7:0] control;
	reg [WIDTH-1:0] reload_low;
	reg [WIDTH-1:0] reload_high;
	reg [7:0] next_control;
	reg [WIDTH-1:0] next_reload_low;
	reg [WIDTH-1:0] next_reload_high;

	wire high_flag = control[`SWT_BIT_HIGH_FLAG];
	wire low_flag = control[`SWT_BIT_LOW_FLAG];
	wire low_irq_en = control[`SWT_BIT_LOW_IRQ_EN];
	wire split = control[`SWT_BIT_SPLIT];
	wire high_cap_sel = control[`SWT_BIT_HIGH_CAP];
	wire low_cap_sel = control[`SWT_BIT_LOW_CAP];
	wire high_run = control[`SWT_BIT_HIGH_RUN];
	wire low_run = control[`SWT_BIT_LOW_RUN];

	// ----------------------------------------
	// low capture pin: two-stage sync and edge
	// ----------------------------------------
	reg cap_low_s1;
	reg cap_low_s2;
	reg cap_low_d;

	always @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			cap_low_s1 <= 1'b0;
			cap_low_s2 <= 1'b0;
			cap_low_d <= 1'b0;
		end
		else
		begin
			cap_low_s1 <= cap_low_i;
			cap_low_s2 <= cap_low_s1;
			cap_low_d <= cap_low_s2;
		end
	end

	// rising edge of the pin is the event
	wire cap_low_edge = cap_low_s2 & ~cap_low_d;

	// ----------------------------------------
	// high capture pin: two-stage sync and edge
	// ----------------------------------------
	reg cap_high_s1;
	reg cap_high_s2;
	reg cap_high_d;

	always @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			cap_high_s1 <= 1'b0;
			cap_high_s2 <= 1'b0;
			cap_high_d <= 1'b0;
		end
		else
		begin
			cap_high_s1 <= cap_high_i;
			cap_high_s2 <= cap_high_s1;
			cap_high_d <= cap_high_s2;
		end
	end

	// rising edge of the pin is the event
	wire cap_high_edge = cap_high_s2 & ~cap_high_d;

	// ----------------------------------------
	// mode decode
	// ----------------------------------------
	wire wide = ~split;
	wire low_cap_mode = low_cap_sel;
	wire high_cap_mode = split ? high_cap_sel : low_cap_sel;
	wire run_l = low_run;
	wire run_h_split = high_run;

	// ----------------------------------------
	// software write strobes
	// ----------------------------------------
	wire wr_control = sfr_wr_i & (sfr_addr_i == `SWT_ADDR_CONTROL);
	wire wr_rel_low = sfr_wr_i & (sfr_addr_i == `SWT_ADDR_RELOAD_LOW);
	wire wr_rel_high = sfr_wr_i & (sfr_addr_i == `SWT_ADDR_RELOAD_HIGH);
	wire wr_cnt_low = sfr_wr_i & (sfr_addr_i == `SWT_ADDR_COUNT_LOW);
	wire wr_cnt_high = sfr_wr_i & (sfr_addr_i == `SWT_ADDR_COUNT_HIGH);

	// ----------------------------------------
	// the two counting halves
	// ----------------------------------------
	wire [WIDTH-1:0] cnt_low;
	wire [WIDTH-1:0] cnt_high;
	wire ovf_low;
	wire ovf_high;
	wire full_low;
	wire full_high;

	wire inc_low = run_l;
	wire inc_high = split ? run_h_split : (run_l & ovf_low);
	// wide timer mode: low byte wraps to zero unless the whole word rolls
	wire rel_en_low = ~low_cap_mode & (split | full_high);
	wire rel_en_high = ~high_cap_mode;

	swt_half #(
		.WIDTH(WIDTH)
	) u_low (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.inc_i(inc_low),
		.wr_i(wr_cnt_low),
		.wdata_i(sfr_wdata_i[WIDTH-1:0]),
		.rel_en_i(rel_en_low),
		.rel_i(reload_low),
		.cnt_o(cnt_low),
		.ovf_o(ovf_low),
		.full_o(full_low)
	);

	swt_half #(
		.WIDTH(WIDTH)
	) u_high (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.inc_i(inc_high),
		.wr_i(wr_cnt_high),
		.wdata_i(sfr_wdata_i[WIDTH-1:0]),
		.rel_en_i(rel_en_high),
		.rel_i(reload_high),
		.cnt_o(cnt_high),
		.ovf_o(ovf_high),
		.full_o(full_high)
	);

	// ----------------------------------------
	// capture and flag events
	// ----------------------------------------
	// wide mode: one capture source serves both halves
	wire cap_evt_low = low_cap_mode & cap_low_edge;
	wire cap_evt_high = split ? (high_cap_mode & cap_high_edge)
		: (low_cap_mode & cap_low_edge);

	reg set_high_flag;
	reg set_low_flag;

	always @*
	begin
		set_high_flag = 1'b0;
		set_low_flag = 1'b0;
		if (split)
		begin
			set_high_flag = cap_evt_high | (ovf_high & ~high_cap_mode);
			set_low_flag = cap_evt_low | (ovf_low & ~low_cap_mode);
		end
		else if (low_cap_mode)
		begin
			set_high_flag = cap_evt_high;
			set_low_flag = ovf_high;
		end
		else
		begin
			set_high_flag = ovf_high;
			set_low_flag = ovf_low;
		end
	end

	// ----------------------------------------
	// control register: software writes and flag sets
	// ----------------------------------------
	always @*
	begin
		next_control = control;
		if (wr_control)
		begin
			next_control = sfr_wdata_i;
		end
		// hardware only ever sets; set wins over a clearing write
		next_control[`SWT_BIT_HIGH_FLAG] =
			next_control[`SWT_BIT_HIGH_FLAG] | set_high_flag;
		next_control[`SWT_BIT_LOW_FLAG] =
			next_control[`SWT_BIT_LOW_FLAG] | set_low_flag;
	end

	// ----------------------------------------
	// reload bytes: software writes and captures
	// ----------------------------------------
	// capture beats a same-cycle software write
	always @*
	begin
		next_reload_low = reload_low;
		next_reload_high = reload_high;
		if (wr_rel_low)
		begin
			next_reload_low = sfr_wdata_i[WIDTH-1:0];
		end
		if (wr_rel_high)
		begin
			next_reload_high = sfr_wdata_i[WIDTH-1:0];
		end
		if (split)
		begin
			if (cap_evt_low)
			begin
				next_reload_low = cnt_low;
			end
			if (cap_evt_high)
			begin
				next_reload_high = cnt_high;
			end
		end
		else if (cap_evt_high)
		begin
			next_reload_low = cnt_low;
			next_reload_high = cnt_high;
		end
	end

	// ----------------------------------------
	// state registers
	// ----------------------------------------
	always @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			control <= `SWT_RST_CONTROL;
		end
		else
		begin
			control <= next_control;
		end
	end

	always @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			reload_low <= `SWT_RST_RELOAD;
		end
		else
		begin
			reload_low <= next_reload_low;
		end
	end

	always @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			reload_high <= `SWT_RST_RELOAD;
		end
		else
		begin
			reload_high <= next_reload_high;
		end
	end

	// ----------------------------------------
	// read data
	// ----------------------------------------
	reg [7:0] next_rdata;

	always @*
	begin
		next_rdata = 8'h00;
		case (sfr_addr_i)
			`SWT_ADDR_CONTROL: next_rdata = control;
			`SWT_ADDR_RELOAD_LOW: next_rdata = reload_low;
			`SWT_ADDR_RELOAD_HIGH: next_rdata = reload_high;
			`SWT_ADDR_COUNT_LOW: next_rdata = cnt_low;
			`SWT_ADDR_COUNT_HIGH: next_rdata = cnt_high;
			default: next_rdata = 8'h00;
		endcase
	end

	always @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			sfr_rdata_o <= 8'h00;
		end
		else
		begin
			sfr_rdata_o <= next_rdata;
		end
	end

	// ----------------------------------------
	// interrupt request
	// ----------------------------------------
	// taken from the next flag state so irq rises with its flag
	wire next_irq = next_control[`SWT_BIT_HIGH_FLAG]
		| (next_control[`SWT_BIT_LOW_FLAG]
		& next_control[`SWT_BIT_LOW_IRQ_EN]);

	always @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			irq_o <= 1'b0;
		end
		else
		begin
			irq_o <= next_irq;
		end
	end

endmodule // swt_timer

// *** core/swt_defs.vh ***
`ifndef SWT_DEFS_VH
`define SWT_DEFS_VH

// ----------------------------------------
// register addresses in the sfr space
// ----------------------------------------
`define SWT_ADDR_CONTROL 8'hb9
`define SWT_ADDR_RELOAD_LOW 8'hca
`define SWT_ADDR_RELOAD_HIGH 8'hcb
`define SWT_ADDR_COUNT_LOW 8'hcc
`define SWT_ADDR_COUNT_HIGH 8'hcd

// ----------------------------------------
// control register fields
// ----------------------------------------
`define SWT_BIT_HIGH_FLAG 7
`define SWT_BIT_LOW_FLAG 6
`define SWT_BIT_LOW_IRQ_EN 5
`define SWT_BIT_SPLIT 4
`define SWT_BIT_HIGH_CAP 3
`define SWT_BIT_LOW_CAP 2
`define SWT_BIT_HIGH_RUN 1
`define SWT_BIT_LOW_RUN 0

// ----------------------------------------
// reset values
// ----------------------------------------
`define SWT_RST_CONTROL 8'h00
`define SWT_RST_RELOAD 8'h00
`define SWT_RST_COUNT 8'h00

`endif

// *** core/swt_half.v ***
// ----------------------------------------
// one counting half of the timer
// ----------------------------------------
module swt_half #(
	parameter WIDTH = 8
) (
	input wire clk_i,
	input wire rst_n_i,
	input wire inc_i,
	input wire wr_i,
	input wire [WIDTH-1:0] wdata_i,
	input wire rel_en_i,
	input wire [WIDTH-1:0] rel_i,
	output reg [WIDTH-1:0] cnt_o,
	output wire ovf_o,
	output wire full_o
);

	reg [WIDTH-1:0] next_cnt;

	assign full_o = &cnt_o;
	assign ovf_o = inc_i & full_o;

	always @*
	begin
		next_cnt = cnt_o;
		if (wr_i)
		begin
			next_cnt = wdata_i;
		end
		else if (ovf_o)
		begin
			next_cnt = rel_en_i ? rel_i : {WIDTH{1'b0}};
		end
		else if (inc_i)
		begin
			next_cnt = cnt_o + {{(WIDTH-1){1'b0}}, 1'b1};
		end
	end

	always @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			cnt_o <= {WIDTH{1'b0}};
		end
		else
		begin
			cnt_o <= next_cnt;
		end
	end

endmodule // swt_half

// *** dv/swt_timer_properties.sv ***
module swt_timer_chk (
	input wire clk_i,
	input wire rst_n_i,
	input wire [7:0] sfr_addr_i,
	input wire sfr_wr_i,
	input wire [7:0] sfr_wdata_i,
	input wire cap_low_i,
	input wire cap_high_i,
	input wire [7:0] sfr_rdata_o,
	input wire irq_o
);
	default clocking dc @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);

	property p_irq_hold;
		irq_o && !sfr_wr_i |=> irq_o;
	endproperty
	a_irq_hold: assert property (p_irq_hold) else $error("irq dropped");
	property p_unmapped;
		!(sfr_addr_i inside {8'hb9, 8'hca, 8'hcb, 8'hcc, 8'hcd})
		|=> sfr_rdata_o == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped");
	property p_ctrl_rb;
		sfr_wr_i && sfr_addr_i == 8'hb9 ##1 sfr_addr_i == 8'hb9
		|=> (sfr_rdata_o & 8'h3f) == ($past(sfr_wdata_i, 2) & 8'h3f);
	endproperty
	a_ctrl_rb: assert property (p_ctrl_rb) else $error("ctrl rb");
	property p_rh_rb;
		sfr_wr_i && sfr_addr_i == 8'hcb ##1 sfr_addr_i == 8'hcb
		|=> sfr_rdata_o == $past(sfr_wdata_i, 2);
	endproperty
	a_rh_rb: assert property (p_rh_rb) else $error("reload hi rb");
	property p_rl_rb;
		sfr_wr_i && sfr_addr_i == 8'hca ##1 sfr_addr_i == 8'hca
		|=> sfr_rdata_o == $past(sfr_wdata_i, 2);
	endproperty
	a_rl_rb: assert property (p_rl_rb) else $error("reload lo rb");
	property p_irq_eq;
		sfr_addr_i == 8'hb9 |=> $past(irq_o) ==
		(sfr_rdata_o[7] | (sfr_rdata_o[6] & sfr_rdata_o[5]));
	endproperty
	a_irq_eq: assert property (p_irq_eq) else $error("irq eq");
	property p_hi_sticky;
		sfr_addr_i == 8'hb9 && !sfr_wr_i ##1
		sfr_addr_i == 8'hb9 && sfr_rdata_o[7] |=> sfr_rdata_o[7];
	endproperty
	a_hi_sticky: assert property (p_hi_sticky) else $error("hi flag");
	property p_lo_sticky;
		sfr_addr_i == 8'hb9 && !sfr_wr_i ##1
		sfr_addr_i == 8'hb9 && sfr_rdata_o[6] |=> sfr_rdata_o[6];
	endproperty
	a_lo_sticky: assert property (p_lo_sticky) else $error("lo flag");
endmodule // swt_timer_chk

bind swt_timer swt_timer_chk i_swt_timer_chk (.clk_i(clk_i),
	.rst_n_i(rst_n_i), .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i),
	.sfr_wdata_i(sfr_wdata_i), .cap_low_i(cap_low_i),
	.cap_high_i(cap_high_i), .sfr_rdata_o(sfr_rdata_o), .irq_o(irq_o));

// *** dv/tb.sv ***
`define CHK(n, e, s) \
	begin \
		num_checks++; \
		if ((s) !== (e)) \
		begin \
			err_total++; \
			$display("Error %s exp %h got %h", n, e, s); \
		end \
	end

module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [7:0] sfr_addr_i = 8'h00;
	logic sfr_wr_i = 1'b0;
	logic [7:0] sfr_wdata_i = 8'h00;
	logic cap_low_i = 1'b0;
	logic cap_high_i = 1'b0;
	wire [7:0] sfr_rdata_o;
	wire irq_o;
	int err_total = 0;
	int num_checks = 0;
	int seed = 80250;
	int cyc = 0;
	logic [7:0] rv;
	logic [7:0] mdl [logic [7:0]];
	logic [7:0] adr [6] = '{8'hb9, 8'hca, 8'hcb, 8'hcc, 8'hcd, 8'hc0};

	swt_timer i_swt_timer (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i),
		.sfr_wdata_i(sfr_wdata_i), .cap_low_i(cap_low_i),
		.cap_high_i(cap_high_i), .sfr_rdata_o(sfr_rdata_o), .irq_o(irq_o));

	initial
	begin
		forever #10 clk_i = ~clk_i;
	end

	task automatic wr(input logic [7:0] ad, input logic [7:0] d);
		@(posedge clk_i);
		sfr_addr_i <= ad;
		sfr_wr_i <= 1'b1;
		sfr_wdata_i <= d;
		@(posedge clk_i);
		sfr_wr_i <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] ad, output logic [7:0] d);
		@(posedge clk_i);
		sfr_addr_i <= ad;
		@(posedge clk_i);
		#1 d = sfr_rdata_o;
	endtask

	task automatic ck(input logic [7:0] ad, input logic [7:0] e);
		rd(ad, rv);
		`CHK($sformatf("reg %h", ad), e, rv)
	endtask

	task automatic pulse(input bit hi);
		@(posedge clk_i);
		cap_high_i <= hi;
		cap_low_i <= !hi;
		repeat (4) @(posedge clk_i);
		cap_high_i <= 1'b0;
		cap_low_i <= 1'b0;
		repeat (4) @(posedge clk_i);
	endtask

	task automatic close_out();
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	always @(posedge clk_i)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			err_total++;
			close_out();
		end
	end

	initial
	begin
		repeat (2) @(posedge clk_i);
		rst_n_i <= 1'b1;
		foreach (adr[i]) ck(adr[i], 8'h00);
		// ----------------------------------------
		// random readback, timer stopped
		// ----------------------------------------
		for (int i = 0; i < 8; i++)
		begin
			mdl[8'hb9] = 8'($random(seed)) & 8'h3c;
			mdl[8'hca] = 8'($random(seed));
			mdl[8'hcb] = 8'($random(seed));
			mdl[8'hcc] = 8'($random(seed));
			mdl[8'hcd] = 8'($random(seed));
			foreach (mdl[k]) wr(k, mdl[k]);
			foreach (mdl[k]) ck(k, mdl[k]);
		end
		// ----------------------------------------
		// wide timer mode
		// ----------------------------------------
		wr(8'hcb, 8'h5a);
		wr(8'hca, 8'h00);
		wr(8'hcc, 8'hfd);
		wr(8'hcd, 8'h12);
		wr(8'hb9, 8'h01);
		repeat (6) @(posedge clk_i);
		ck(8'hb9, 8'h41);
		`CHK("irq", 1'b0, irq_o)
		ck(8'hcd, 8'h13);
		wr(8'hb9, 8'h61);
		ck(8'hb9, 8'h61);
		`CHK("irq", 1'b1, irq_o)
		wr(8'hb9, 8'h01);
		ck(8'hb9, 8'h01);
		wr(8'hcd, 8'hff);
		wr(8'hcc, 8'hf8);
		wr(8'hcb, 8'h77);
		repeat (12) @(posedge clk_i);
		ck(8'hb9, 8'hc1);
		`CHK("irq", 1'b1, irq_o)
		ck(8'hcd, 8'h77);
		wr(8'hb9, 8'h00);
		ck(8'hb9, 8'h00);
		// ----------------------------------------
		// wide capture mode
		// ----------------------------------------
		wr(8'hcd, 8'h34);
		wr(8'hcc, 8'h00);
		wr(8'hb9, 8'h05);
		pulse(1'b1);
		ck(8'hb9, 8'h05);
		pulse(1'b0);
		ck(8'hb9, 8'h85);
		ck(8'hcb, 8'h34);
		wr(8'hcd, 8'hff);
		wr(8'hcc, 8'hf0);
		repeat (20) @(posedge clk_i);
		ck(8'hb9, 8'hc5);
		// ----------------------------------------
		// split configuration
		// ----------------------------------------
		wr(8'hb9, 8'h00);
		wr(8'hcc, 8'h00);
		wr(8'hcd, 8'h00);
		wr(8'hb9, 8'h12);
		repeat (8) @(posedge clk_i);
		ck(8'hcc, 8'h00);
		rd(8'hcd, rv);
		`CHK("high count", 1'b1, rv != 8'h00)
		wr(8'hb9, 8'h02);
		rd(8'hcc, rv);
		ck(8'hcc, rv);
		wr(8'hb9, 8'h1a);
		pulse(1'b1);
		ck(8'hb9, 8'h9a);
		wr(8'hcc, 8'hf0);
		wr(8'hb9, 8'h11);
		repeat (20) @(posedge clk_i);
		ck(8'hb9, 8'h51);
		wr(8'hb9, 8'h14);
		pulse(1'b0);
		ck(8'hb9, 8'h54);
		close_out();
	end
endmodule // tb
